/* File: rtl/servo_out_pkg.sv */
// ****************************************************************
// Shared constants and types of the status-output select block.
// ****************************************************************
package servo_out_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets of the register words.
  localparam logic [7:0] SEL_OFS = 8'h00;
  localparam logic [7:0] LIMCFG_OFS = 8'h04;
  localparam logic [7:0] LIMACT_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0c;
  localparam logic [7:0] TLIM_OFS = 8'h10;
  localparam logic [7:0] FLAGS_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
  localparam logic [7:0] REMOTE_OFS = 8'h20;

  // Values after reset.
  localparam logic [11:0] SEL_RESET = 12'h210;
  localparam logic [15:0] LIMCFG_RESET = 16'h0000;
  localparam logic [15:0] TLIM_RESET = 16'h7fff;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [1:0] REMOTE_RESET = 2'h0;

  // Field positions.
  localparam int unsigned FWD_DIS_BIT = 4;
  localparam int unsigned REV_DIS_BIT = 8;
  localparam int unsigned CTRL_APPLY_BIT = 0;
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned NUM_PAIRS = 3;
  localparam int unsigned NUM_FLAGS = 12;

  // Interrupt status bits.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_OT = 0;
  localparam int unsigned IRQ_ALARM = 1;
  localparam int unsigned IRQ_TLIM = 2;
  localparam int unsigned IRQ_READY_LOST = 3;

  // Selection digit codes.
  typedef enum logic [3:0] {
    SEL_IN_POS = 4'h0,
    SEL_ROT_DET = 4'h1,
    SEL_READY = 4'h2,
    SEL_TLIM = 4'h3,
    SEL_BRAKE = 4'h4,
    SEL_INDEX = 4'h5,
    SEL_OT = 4'h6,
    SEL_EXCITE = 4'h7,
    SEL_HOME = 4'h8,
    SEL_TDET = 4'h9,
    SEL_REMOTE1 = 4'ha,
    SEL_REMOTE2 = 4'hb
  } sel_code_t;

  // Drive inputs arriving from outside the clock domain.
  typedef struct packed {
    logic servo_on;
    logic prep_done;
    logic alarm;
    logic main_power;
    logic index_mark;
    logic forward_limit_in;
    logic reverse_limit_in;
    logic excited;
  } drive_pins_t;

  // One flag per selection code, active low, indexed by the code.
  typedef logic [NUM_FLAGS-1:0] flag_vec_t;

endpackage

/* File: rtl/output_pair_mux.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// One output terminal pair: picks a flag by its selection digit.
// ****************************************************************
module output_pair_mux
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire servo_out_pkg::flag_vec_t flags_i,
  input wire logic [3:0] sel_i,
  output logic pair_n_o
);

  // Registered copy of the selected flag; high means inactive.
  logic pair_n_q;

  // The copy is refreshed every cycle so a new selection acts on the next edge.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pair_n_q <= 1'b1;
    end
    else if (sel_i < 4'(servo_out_pkg::NUM_FLAGS))
    begin
      pair_n_q <= flags_i[sel_i];
    end
    else
    begin
      // Codes past the table leave the pair off.
      pair_n_q <= 1'b1;
    end
  end

  assign pair_n_o = pair_n_q;

  // A valid code shows the selected flag one cycle later.
  pair_follow_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (sel_i < 4'hc) |=> (pair_n_o == $past(flags_i[sel_i])))
    else $error("pair output does not follow selected flag");

  // An invalid code keeps the pair high.
  pair_invalid_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (sel_i >= 4'hc) |=> pair_n_o)
    else $error("pair with invalid selection is not high");

  // Code three routes the torque-limited flag.
  pair_tlim_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (sel_i == 4'h3) |=> (pair_n_o == $past(flags_i[3])))
    else $error("code three does not route torque-limited flag");

endmodule // output_pair_mux
`default_nettype wire

/* File: rtl/servo_status_output_select.sv */
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Status flags of the drive and their routing to output pairs.
// ****************************************************************
// How it works
// - Ready low only after servo-on and preparation.
// - Alarm or lost main power clears ready.
// - Index output low while shaft at index.
// - Config digits disable forward/reverse limits after restart.
// - Both limits disabled keeps overtravel on.
// - Excitation low while enabled and excited.
// - Torque-limited low while reference exceeds limit.
// - Torque-limited works in every control mode.
// - Nine flags unassigned after reset.
// - One digit per pair; three selects torque-limited.
// - Digit codes decode to twelve flags.
module servo_status_output_select
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire servo_out_pkg::drive_pins_t pins_i,
  input wire logic [15:0] torque_ref_i,
  input wire logic in_position_n_i,
  input wire logic rotation_detect_n_i,
  input wire logic brake_interlock_n_i,
  input wire logic home_done_n_i,
  input wire logic torque_detect_n_i,
  output logic [2:0] pair_n_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // First stage; read by the second stage only.
  logic [7:0] meta_q;
  // Second stage; safe for logic.
  logic [7:0] sync_q;
  // Synchronised pins viewed as fields.
  servo_out_pkg::drive_pins_t pins_s;

  // Each pin bit gets its own two-flop chain.
  generate
    for (genvar b = 0; b < 8; b++)
    begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          meta_q[b] <= 1'b0;
          sync_q[b] <= 1'b0;
        end
        else
        begin
          meta_q[b] <= pins_i[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  assign pins_s = sync_q;

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Selection digits, one per pair.
  logic [11:0] sel_q;
  // Limit configuration as written; not yet in force.
  logic [15:0] limcfg_q;
  // Limit configuration in force since the last restart.
  logic [15:0] limact_q;
  // Torque limit setting.
  logic [15:0] tlim_q;
  // Sticky event bits and their mask.
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  // Remote output bits; one means output on.
  logic [1:0] remote_q;
  // Flag vector, active low, one cycle behind the side inputs, three behind the drive pins.
  servo_out_pkg::flag_vec_t flags_q;
  servo_out_pkg::flag_vec_t flags_d;
  // Read data and interrupt output.
  logic [31:0] rdata_q;
  logic irq_q;

  // Decoded write strobes.
  logic wr_sel;
  logic wr_limcfg;
  logic wr_ctrl;
  logic wr_tlim;
  logic wr_stat;
  logic wr_mask;
  logic wr_remote;
  // Restart request: loads the pending limit configuration.
  logic apply;

  assign wr_sel = wr_i && (addr_i == servo_out_pkg::SEL_OFS);
  assign wr_limcfg = wr_i && (addr_i == servo_out_pkg::LIMCFG_OFS);
  assign wr_ctrl = wr_i && (addr_i == servo_out_pkg::CTRL_OFS);
  assign wr_tlim = wr_i && (addr_i == servo_out_pkg::TLIM_OFS);
  assign wr_stat = wr_i && (addr_i == servo_out_pkg::IRQ_STAT_OFS);
  assign wr_mask = wr_i && (addr_i == servo_out_pkg::IRQ_MASK_OFS);
  assign wr_remote = wr_i && (addr_i == servo_out_pkg::REMOTE_OFS);
  assign apply = wr_ctrl && wdata_i[servo_out_pkg::CTRL_APPLY_BIT];

  // Selection starts with no pair on the nine flags past code two.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_q <= servo_out_pkg::SEL_RESET;
    end
    else if (wr_sel)
    begin
      sel_q <= wdata_i[11:0];
    end
  end

  // Limit configuration: written freely, but only a restart makes it
  // act, so the limits never change meaning in mid-motion.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      limcfg_q <= servo_out_pkg::LIMCFG_RESET;
      limact_q <= servo_out_pkg::LIMCFG_RESET;
    end
    else
    begin
      if (wr_limcfg)
      begin
        limcfg_q <= wdata_i[15:0];
      end
      if (apply)
      begin
        limact_q <= limcfg_q;
      end
    end
  end

  // Torque limit and remote outputs are plain storage.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tlim_q <= servo_out_pkg::TLIM_RESET;
      remote_q <= servo_out_pkg::REMOTE_RESET;
      irq_mask_q <= servo_out_pkg::IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_tlim)
      begin
        tlim_q <= wdata_i[15:0];
      end
      if (wr_remote)
      begin
        remote_q <= wdata_i[1:0];
      end
      if (wr_mask)
      begin
        irq_mask_q <= wdata_i[3:0];
      end
    end
  end

  // ****************************************************************
  // Flag generation
  // ****************************************************************

  // Limit disables in force.
  logic fwd_dis;
  logic rev_dis;
  // Raw active-high conditions.
  logic ready_on;
  logic ot_off;
  logic excite_on;
  logic tlim_on;

  assign fwd_dis = limact_q[servo_out_pkg::FWD_DIS_BIT];
  assign rev_dis = limact_q[servo_out_pkg::REV_DIS_BIT];
  // Ready needs servo-on, finished preparation, no alarm and power.
  assign ready_on = pins_s.servo_on && pins_s.prep_done
    && !pins_s.alarm && pins_s.main_power;
  // A disabled limit is ignored, so both disabled leaves it on.
  assign ot_off = (pins_s.forward_limit_in && !fwd_dis)
    || (pins_s.reverse_limit_in && !rev_dis);
  assign excite_on = pins_s.servo_on && pins_s.excited;
  // No mode input gates this compare, so it holds in every mode.
  assign tlim_on = torque_ref_i > tlim_q;

  // Flags by code; each is low when its condition is on.
  always_comb
  begin
    flags_d = '1;
    flags_d[servo_out_pkg::SEL_IN_POS] = in_position_n_i;
    flags_d[servo_out_pkg::SEL_ROT_DET] = rotation_detect_n_i;
    flags_d[servo_out_pkg::SEL_READY] = !ready_on;
    flags_d[servo_out_pkg::SEL_TLIM] = !tlim_on;
    flags_d[servo_out_pkg::SEL_BRAKE] = brake_interlock_n_i;
    // The width follows the mark itself, hence the speed.
    flags_d[servo_out_pkg::SEL_INDEX] = !pins_s.index_mark;
    flags_d[servo_out_pkg::SEL_OT] = ot_off;
    flags_d[servo_out_pkg::SEL_EXCITE] = !excite_on;
    flags_d[servo_out_pkg::SEL_HOME] = home_done_n_i;
    flags_d[servo_out_pkg::SEL_TDET] = torque_detect_n_i;
    flags_d[servo_out_pkg::SEL_REMOTE1] = !remote_q[0];
    flags_d[servo_out_pkg::SEL_REMOTE2] = !remote_q[1];
  end

  // Flags are registered once so every pair sees the same sample.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flags_q <= '1;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Events: overtravel going off, alarm rising, limit entered,
  // ready lost. Overtravel and ready are rising flag edges, the limit a falling one, alarm a pin edge.
  logic [3:0] irq_ev;
  // Last alarm sample for edge detection.
  logic alarm_seen_q;

  assign irq_ev[servo_out_pkg::IRQ_OT] =
    flags_d[servo_out_pkg::SEL_OT] && !flags_q[servo_out_pkg::SEL_OT];
  assign irq_ev[servo_out_pkg::IRQ_ALARM] =
    pins_s.alarm && !alarm_seen_q;
  assign irq_ev[servo_out_pkg::IRQ_TLIM] =
    !flags_d[servo_out_pkg::SEL_TLIM] && flags_q[servo_out_pkg::SEL_TLIM];
  assign irq_ev[servo_out_pkg::IRQ_READY_LOST] =
    flags_d[servo_out_pkg::SEL_READY] && !flags_q[servo_out_pkg::SEL_READY];

  // Sticky status; an event in the clearing cycle still sets the bit.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_stat_q <= '0;
      alarm_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      alarm_seen_q <= pins_s.alarm;
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_i[3:0] : 4'h0))
        | irq_ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ****************************************************************
  // Register read port
  // ****************************************************************

  // Read data stand in the cycle after the strobe, else zero.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_q <= '0;
    end
    else if (!rd_i)
    begin
      rdata_q <= '0;
    end
    else if (addr_i == servo_out_pkg::SEL_OFS)
    begin
      rdata_q <= {20'h00000, sel_q};
    end
    else if (addr_i == servo_out_pkg::LIMCFG_OFS)
    begin
      rdata_q <= {16'h0000, limcfg_q};
    end
    else if (addr_i == servo_out_pkg::LIMACT_OFS)
    begin
      rdata_q <= {16'h0000, limact_q};
    end
    else if (addr_i == servo_out_pkg::TLIM_OFS)
    begin
      rdata_q <= {16'h0000, tlim_q};
    end
    else if (addr_i == servo_out_pkg::FLAGS_OFS)
    begin
      rdata_q <= {20'h00000, flags_q};
    end
    else if (addr_i == servo_out_pkg::IRQ_STAT_OFS)
    begin
      rdata_q <= {28'h0000000, irq_stat_q};
    end
    else if (addr_i == servo_out_pkg::IRQ_MASK_OFS)
    begin
      rdata_q <= {28'h0000000, irq_mask_q};
    end
    else if (addr_i == servo_out_pkg::REMOTE_OFS)
    begin
      rdata_q <= {30'h00000000, remote_q};
    end
    else
    begin
      // Control word and unmapped addresses read as zero.
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************************************
  // Output pairs
  // ****************************************************************

  generate
    for (genvar p = 0; p < 3; p++)
    begin : g_pair
      output_pair_mux u_pair
      (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .flags_i(flags_q),
        .sel_i(sel_q[p*4 +: 4]),
        .pair_n_o(pair_n_o[p])
      );
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence fault_seen;
    pins_s.alarm || !pins_s.main_power;
  endsequence

  sequence all_ready;
    pins_s.servo_on && pins_s.prep_done && !pins_s.alarm
      && pins_s.main_power;
  endsequence

  ready_fault_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    fault_seen |=> flags_q[2])
    else $error("ready asserted during alarm or power loss");

  ready_on_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    all_ready |=> !flags_q[2])
    else $error("ready not asserted when servo prepared");

  index_follow_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 (flags_q[5] == !$past(pins_s.index_mark)))
    else $error("index output does not follow the mark");

  ot_off_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (pins_s.forward_limit_in && !fwd_dis) |=> flags_q[6])
    else $error("overtravel on while forward limit active");

  ot_both_dis_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (fwd_dis && rev_dis) |=> !flags_q[6])
    else $error("overtravel off with both limits disabled");

  limcfg_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !apply |=> $stable(limact_q))
    else $error("limit configuration changed without restart");

  excite_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (pins_s.servo_on && pins_s.excited) |=> !flags_q[7])
    else $error("excitation output not low while excited");

  tlim_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 (flags_q[3] == !($past(torque_ref_i) > $past(tlim_q))))
    else $error("torque-limited flag wrong");

  irq_level_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 (irq_o == $past(|(irq_stat_q & irq_mask_q))))
    else $error("interrupt output does not track masked status");

  set_wins_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (irq_ev[0] && wr_stat) |=> irq_stat_q[0])
    else $error("event lost during status clear");

endmodule // servo_status_output_select
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host motion controller that watches the overtravel output pair.
// ****************************************************************
module host_model
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ot_n_i,
  output logic refs_on_o
);
  // References are held back while the watched pair reads OFF.
  // An unknown pair also counts as OFF, so the host errs on the safe side.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      refs_on_o <= 1'b0;
    else
      refs_on_o <= (ot_n_i === 1'b0);
  end
endmodule // host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bench of the status-output select block.
// ****************************************************************
module testbench;
  logic ref_clk_i = 1'b0; // System clock, 50 MHz.
  logic rst_b_i = 1'b0; // Reset, active low.
  logic [7:0] addr = 8'h00; // Register address.
  logic [31:0] wdata = 32'h0; // Register write data.
  logic wr = 1'b0; // Write strobe.
  logic rd = 1'b0; // Read strobe.
  logic [31:0] rdata; // Read data from the block.
  logic irq; // Interrupt level.
  servo_out_pkg::drive_pins_t pins = '0; // Drive inputs.
  logic [15:0] tref = 16'h0000; // Internal torque reference.
  logic [4:0] side_n = 5'h1f; // In-pos, rotation, brake, home, torque det.
  logic [2:0] pair_n; // Output terminal pairs.
  logic refs_on; // Host reference enable.
  int errors = 0; // Mismatch count.
  int checked = 0; // Comparison count.
  logic [3:0] cds [5] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'h9}; // Side codes.

  // Clock generator.
  always #10 ref_clk_i = ~ref_clk_i;

  servo_status_output_select uut
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .irq_o(irq),
    .pins_i(pins),
    .torque_ref_i(tref),
    .in_position_n_i(side_n[0]),
    .rotation_detect_n_i(side_n[1]),
    .brake_interlock_n_i(side_n[2]),
    .home_done_n_i(side_n[3]),
    .torque_detect_n_i(side_n[4]),
    .pair_n_o(pair_n)
  );

  host_model host
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ot_n_i(pair_n[2]),
    .refs_on_o(refs_on)
  );

  // ****************************************************************
  // Bus tasks and comparisons.
  // ****************************************************************
  // One write cycle; the strobe drops at the next edge.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  // Compares one register-sized value.
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One read cycle; data stand only in the following cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    @(negedge ref_clk_i);
    chk_reg(rdata, exp);
  endtask

  // Pins need four edges to reach a pair; six leaves margin.
  task automatic settle();
    repeat (6) @(posedge ref_clk_i);
  endtask

  // Compares the three output pairs at a settled point.
  task automatic chk_pairs(input logic [2:0] exp);
    @(negedge ref_clk_i);
    checked++;
    if (pair_n !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, pair_n, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hung run short.
  initial
  begin
    #1000000;
    errors++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd_chk(servo_out_pkg::SEL_OFS, 32'h210);
    rd_chk(servo_out_pkg::LIMCFG_OFS, 32'h0);
    rd_chk(servo_out_pkg::TLIM_OFS, 32'h7fff);
    rd_chk(servo_out_pkg::IRQ_MASK_OFS, 32'h0);
    rd_chk(8'h24, 32'h0);
    chk_pairs(3'b111);
    $display("test reset done");
    // Ready needs servo-on, preparation, power and no alarm.
    @(posedge ref_clk_i) pins.servo_on <= 1'b1;
    @(posedge ref_clk_i) pins.main_power <= 1'b1;
    settle();
    chk_pairs(3'b111);
    @(posedge ref_clk_i) pins.prep_done <= 1'b1;
    settle();
    chk_pairs(3'b011);
    @(posedge ref_clk_i) pins.alarm <= 1'b1;
    settle();
    chk_pairs(3'b111);
    rd_chk(servo_out_pkg::IRQ_STAT_OFS, 32'ha);
    wr_reg(servo_out_pkg::IRQ_MASK_OFS, 32'h2);
    settle();
    chk_reg({31'h0, irq}, 32'h1);
    wr_reg(servo_out_pkg::IRQ_STAT_OFS, 32'ha);
    settle();
    chk_reg({31'h0, irq}, 32'h0);
    @(posedge ref_clk_i) pins.alarm <= 1'b0;
    settle();
    chk_pairs(3'b011);
    @(posedge ref_clk_i) pins.main_power <= 1'b0;
    settle();
    chk_pairs(3'b111);
    $display("test ready done");
    // Pair 0 torque limited, pair 1 index, pair 2 overtravel.
    wr_reg(servo_out_pkg::SEL_OFS, 32'h653);
    settle();
    chk_pairs(3'b011);
    chk_reg({31'h0, refs_on}, 32'h1);
    @(posedge ref_clk_i) tref <= 16'h8000;
    settle();
    chk_pairs(3'b010);
    @(posedge ref_clk_i) tref <= 16'h7fff;
    settle();
    chk_pairs(3'b011);
    wr_reg(servo_out_pkg::TLIM_OFS, 32'h100);
    @(posedge ref_clk_i) tref <= 16'h0101;
    settle();
    chk_pairs(3'b010);
    @(posedge ref_clk_i) tref <= 16'h0000;
    @(posedge ref_clk_i) pins.index_mark <= 1'b1;
    settle();
    chk_pairs(3'b001);
    @(posedge ref_clk_i) pins.index_mark <= 1'b0;
    @(posedge ref_clk_i) pins.forward_limit_in <= 1'b1;
    settle();
    chk_pairs(3'b111);
    chk_reg({31'h0, refs_on}, 32'h0);
    @(posedge ref_clk_i) pins.reverse_limit_in <= 1'b1;
    wr_reg(servo_out_pkg::LIMCFG_OFS, 32'h110);
    settle();
    chk_pairs(3'b111);
    rd_chk(servo_out_pkg::LIMACT_OFS, 32'h0);
    wr_reg(servo_out_pkg::CTRL_OFS, 32'h1);
    settle();
    chk_pairs(3'b011);
    rd_chk(servo_out_pkg::LIMACT_OFS, 32'h110);
    wr_reg(servo_out_pkg::LIMCFG_OFS, 32'h010);
    wr_reg(servo_out_pkg::CTRL_OFS, 32'h1);
    settle();
    chk_pairs(3'b111);
    @(posedge ref_clk_i) pins.reverse_limit_in <= 1'b0;
    settle();
    chk_pairs(3'b011);
    $display("test limits done");
    // Excitation, an invalid code and remote output 2.
    wr_reg(servo_out_pkg::SEL_OFS, 32'hbc7);
    settle();
    chk_pairs(3'b111);
    @(posedge ref_clk_i) pins.excited <= 1'b1;
    settle();
    chk_pairs(3'b110);
    wr_reg(servo_out_pkg::REMOTE_OFS, 32'h2);
    settle();
    chk_pairs(3'b010);
    @(posedge ref_clk_i) pins.servo_on <= 1'b0;
    settle();
    chk_pairs(3'b011);
    // Each side flag through pair 0, the other pairs invalid.
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(servo_out_pkg::SEL_OFS, {20'h00000, 8'hcc, cds[i]});
      @(posedge ref_clk_i) side_n <= ~(5'h01 << i);
      settle();
      chk_pairs(3'b110);
    end
    @(posedge ref_clk_i) side_n <= 5'h1f;
    wr_reg(servo_out_pkg::REMOTE_OFS, 32'h1);
    wr_reg(servo_out_pkg::SEL_OFS, 32'hcca);
    settle();
    chk_pairs(3'b110);
    $display("test codes done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
